// ==== hdl/scibr_top.sv ====
// Break/reception status, shared data buffer and bit rate generator
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`include "scibr_params.svh"

module scibr_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rxLine,
  output logic slotTick,
  output logic [7:0] txData,
  output logic txLoad,
  output scibr_pkg::scibr_rx_event_t rxEvent
);

  // ==========================================================
  // Receive line synchroniser
  logic rxMeta_q;
  logic rxSync_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxMeta_q <= 1'b1;
      rxSync_q <= 1'b1;
    end else begin
      rxMeta_q <= rxLine;
      rxSync_q <= rxMeta_q;
    end
  end

  // ==========================================================
  // Bus slave
  logic waitReq_q;
  logic waitReq_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  scibr_pkg::scibr_rate_t rate_q;
  scibr_pkg::scibr_rate_t rate_d;
  logic [1:0] ctrl_q;
  logic [1:0] ctrl_d;
  logic brkReadArm_q;
  logic brkReadArm_d;
  logic txLoad_q;
  logic txLoad_d;
  logic breakFlag_q;
  logic rxActive_q;
  logic [7:0] rxData_q;
  logic [7:0] txData_q;
  logic accDone;
  logic rdDone;
  logic wrDone;
  logic lane0;
  logic dataRead;
  logic brkClear;

  // Answer one cycle after the request is first seen
  assign accDone = (avs_read || avs_write) && !waitReq_q;
  assign rdDone = accDone && avs_read;
  assign wrDone = accDone && avs_write;
  assign lane0 = avs_byteenable[0];
  assign dataRead = rdDone && (avs_address == `SCIBR_ADDR_DATA);
  assign brkClear = dataRead && brkReadArm_q;

  always_comb begin
    waitReq_d = 1'b1;
    if ((avs_read || avs_write) && waitReq_q) begin
      waitReq_d = 1'b0;
    end
    rdata_d = rdata_q;
    if (avs_read && waitReq_q) begin
      rdata_d = 32'h0000_0000;
      case (avs_address)
        `SCIBR_ADDR_DATA: rdata_d[7:0] = rxData_q;
        `SCIBR_ADDR_STATUS2: begin
          // Flags only readable, no request out
          rdata_d[`SCIBR_STS2_RPF_BIT] = rxActive_q;
          rdata_d[`SCIBR_STS2_BRK_BIT] = breakFlag_q;
        end
        `SCIBR_ADDR_RATE: begin
          rdata_d[`SCIBR_RATE_SEL_MSB:`SCIBR_RATE_SEL_LSB] = rate_q.rateDivisorSelect;
          rdata_d[`SCIBR_PRE_SEL_MSB:`SCIBR_PRE_SEL_LSB] = rate_q.prescaleSelect;
        end
        `SCIBR_ADDR_CTRL: rdata_d[1:0] = ctrl_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    rate_d = rate_q;
    ctrl_d = ctrl_q;
    txLoad_d = 1'b0;
    if (wrDone && lane0) begin
      case (avs_address)
        `SCIBR_ADDR_RATE: begin
          rate_d.rateDivisorSelect = avs_writedata[`SCIBR_RATE_SEL_MSB:`SCIBR_RATE_SEL_LSB];
          rate_d.prescaleSelect = avs_writedata[`SCIBR_PRE_SEL_MSB:`SCIBR_PRE_SEL_LSB];
        end
        `SCIBR_ADDR_CTRL: ctrl_d = avs_writedata[1:0];
        `SCIBR_ADDR_DATA: txLoad_d = 1'b1;
        default: txLoad_d = 1'b0;
      endcase
    end
    // Arm only if the flag was seen set; any other data read disarms
    brkReadArm_d = brkReadArm_q;
    if (rdDone && avs_address == `SCIBR_ADDR_STATUS2) begin
      // Shown value, so a flag set during the read is never cleared unseen
      brkReadArm_d = rdata_q[`SCIBR_STS2_BRK_BIT];
    end else if (dataRead) begin
      brkReadArm_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      waitReq_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
      rate_q.rateDivisorSelect <= `SCIBR_RATE_RESET;
      rate_q.prescaleSelect <= `SCIBR_PRE_RESET;
      ctrl_q <= `SCIBR_CTRL_RESET;
      brkReadArm_q <= 1'b0;
      txLoad_q <= 1'b0;
    end else begin
      waitReq_q <= waitReq_d;
      rdata_q <= rdata_d;
      rate_q <= rate_d;
      ctrl_q <= ctrl_d;
      brkReadArm_q <= brkReadArm_d;
      txLoad_q <= txLoad_d;
    end
  end

  // ==========================================================
  // Bit rate generator
  logic [5:0] preCnt_q;
  logic [5:0] preCnt_d;
  logic [6:0] rateCnt_q;
  logic [6:0] rateCnt_d;
  logic slotTick_q;
  logic slotTick_d;
  logic [5:0] preMax;
  logic [6:0] rateMax;

  // Prescale divisor, times four clocks per slot
  always_comb begin
    case (rate_q.prescaleSelect)
      2'h0: preMax = 6'(`SCIBR_CLK_PER_SLOT_BASE * 1 - 1);
      2'h1: preMax = 6'(`SCIBR_CLK_PER_SLOT_BASE * 3 - 1);
      2'h2: preMax = 6'(`SCIBR_CLK_PER_SLOT_BASE * 4 - 1);
      default: preMax = 6'(`SCIBR_CLK_PER_SLOT_BASE * 13 - 1);
    endcase
  end

  // Rate divisor is a power of two
  assign rateMax = 7'((8'h01 << rate_q.rateDivisorSelect) - 8'h01);

  // Slot rate over 16 slots gives a bit rate of clock over 64*PD*BD
  always_comb begin
    preCnt_d = preCnt_q + 6'h01;
    rateCnt_d = rateCnt_q;
    slotTick_d = 1'b0;
    if (preCnt_q >= preMax) begin
      preCnt_d = 6'h00;
      rateCnt_d = rateCnt_q + 7'h01;
      if (rateCnt_q >= rateMax) begin
        rateCnt_d = 7'h00;
        slotTick_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      preCnt_q <= 6'h00;
      rateCnt_q <= 7'h00;
      slotTick_q <= 1'b0;
    end else begin
      preCnt_q <= preCnt_d;
      rateCnt_q <= rateCnt_d;
      slotTick_q <= slotTick_d;
    end
  end

  // ==========================================================
  // Receiver framing, break and activity detection
  scibr_pkg::scibr_rx_state_t rxState_q;
  scibr_pkg::scibr_rx_state_t rxState_d;
  logic [3:0] slot_q;
  logic [3:0] slot_d;
  logic [3:0] bitCnt_q;
  logic [3:0] bitCnt_d;
  logic [8:0] shift_q;
  logic [8:0] shift_d;
  logic [7:0] idleCnt_q;
  logic [7:0] idleCnt_d;
  logic breakFlag_d;
  logic breakArm_q;
  logic breakArm_d;
  logic rxActive_d;
  scibr_pkg::scibr_rx_event_t evt_q;
  scibr_pkg::scibr_rx_event_t evt_d;
  logic rxLoad;
  logic [3:0] bitsNeeded;
  logic breakSeen;
  logic rxEnable;
  logic nineMode;

  assign rxEnable = ctrl_q[`SCIBR_CTRL_RXEN_BIT];
  assign nineMode = ctrl_q[`SCIBR_CTRL_NINE_BIT];
  assign bitsNeeded = nineMode ? 4'h9 : 4'h8;

  always_comb begin
    rxState_d = rxState_q;
    slot_d = slot_q;
    bitCnt_d = bitCnt_q;
    shift_d = shift_q;
    idleCnt_d = idleCnt_q;
    rxActive_d = rxActive_q;
    evt_d = evt_q;
    evt_d.rxFullSet = 1'b0;
    evt_d.frameErrSet = 1'b0;
    rxLoad = 1'b0;
    breakSeen = 1'b0;
    // Line must return high before a new break counts
    breakArm_d = breakArm_q || rxSync_q;
    if (!rxEnable) begin
      rxState_d = scibr_pkg::RX_IDLE;
      rxActive_d = 1'b0;
      idleCnt_d = 8'h00;
    end else if (slotTick_q) begin
      slot_d = slot_q + 4'h1;
      case (rxState_q)
        scibr_pkg::RX_IDLE: begin
          if (!rxSync_q) begin
            // Low in the first slot of start search
            rxActive_d = 1'b1;
            rxState_d = scibr_pkg::RX_START;
            slot_d = 4'h1;
            idleCnt_d = 8'h00;
          end else if (idleCnt_q < `SCIBR_IDLE_SLOTS) begin
            idleCnt_d = idleCnt_q + 8'h01;
          end else begin
            // Ten bit times of ones is an idle character
            rxActive_d = 1'b0;
          end
        end
        scibr_pkg::RX_START: begin
          if (slot_q == `SCIBR_SLOT_MID && rxSync_q) begin
            // False start drops the activity flag
            rxActive_d = 1'b0;
            rxState_d = scibr_pkg::RX_IDLE;
          end else if (slot_q == `SCIBR_SLOT_LAST) begin
            rxState_d = scibr_pkg::RX_DATA;
            bitCnt_d = 4'h0;
          end
        end
        scibr_pkg::RX_DATA: begin
          if (slot_q == `SCIBR_SLOT_MID) begin
            // Least significant bit first
            shift_d = {rxSync_q, shift_q[8:1]};
            if (!nineMode) begin
              shift_d = {1'b0, rxSync_q, shift_q[7:1]};
            end
            bitCnt_d = bitCnt_q + 4'h1;
          end else if (slot_q == `SCIBR_SLOT_LAST && bitCnt_q == bitsNeeded) begin
            rxState_d = scibr_pkg::RX_STOP;
          end
        end
        scibr_pkg::RX_STOP: begin
          if (slot_q == `SCIBR_SLOT_MID) begin
            rxLoad = 1'b1;
            evt_d.rxFullSet = 1'b1;
            evt_d.frameErrSet = !rxSync_q;
            evt_d.ninthBit = nineMode ? shift_q[8] : shift_q[7];
            breakSeen = !rxSync_q && (shift_q == 9'h000);
            if (breakSeen) begin
              // Break also reports framing error and full
              evt_d.frameErrSet = 1'b1;
              // Break forces the ninth bit low
              evt_d.ninthBit = 1'b0;
            end
            rxState_d = scibr_pkg::RX_IDLE;
            idleCnt_d = 8'h00;
          end
        end
        default: rxState_d = scibr_pkg::RX_IDLE;
      endcase
    end
    // Break sets the flag only when armed
    breakFlag_d = breakFlag_q;
    if (brkClear) begin
      breakFlag_d = 1'b0;
    end
    if (breakSeen && breakArm_q) begin
      // Set wins over a clear in the same cycle
      breakFlag_d = 1'b1;
    end
    if (breakSeen) begin
      breakArm_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxState_q <= scibr_pkg::RX_IDLE;
      slot_q <= 4'h0;
      bitCnt_q <= 4'h0;
      shift_q <= 9'h000;
      idleCnt_q <= 8'h00;
      breakFlag_q <= 1'b0;
      breakArm_q <= 1'b1;
      rxActive_q <= 1'b0;
      evt_q <= '0;
    end else begin
      rxState_q <= rxState_d;
      slot_q <= slot_d;
      bitCnt_q <= bitCnt_d;
      shift_q <= shift_d;
      idleCnt_q <= idleCnt_d;
      breakFlag_q <= breakFlag_d;
      breakArm_q <= breakArm_d;
      rxActive_q <= rxActive_d;
      evt_q <= evt_d;
    end
  end

  // ==========================================================
  // Data buffer, two separate stores at one address
  logic [7:0] rxData_d;
  logic [7:0] txData_d;

  always_comb begin
    rxData_d = rxData_q;
    txData_d = txData_q;
    if (rxLoad) begin
      rxData_d = shift_q[7:0];
    end
    if (wrDone && lane0 && avs_address == `SCIBR_ADDR_DATA) begin
      txData_d = avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    rxData_q <= rxData_d;
    txData_q <= txData_d;
  end

  // ==========================================================
  // Outputs
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = waitReq_q;
  // Same slot tick serves transmitter too
  assign slotTick = slotTick_q;
  assign txData = txData_q;
  assign txLoad = txLoad_q;
  assign rxEvent = evt_q;

endmodule : scibr_top

// ==== hdl/scibr_params.svh ====
// Constants for the break/status, data buffer and bit rate block
// ==========================================================
`ifndef SCIBR_PARAMS_SVH
`define SCIBR_PARAMS_SVH

// ==========================================================
// Register byte addresses
`define SCIBR_ADDR_DATA 8'h18
`define SCIBR_ADDR_STATUS2 8'h1c
`define SCIBR_ADDR_RATE 8'h20
`define SCIBR_ADDR_CTRL 8'h24

// ==========================================================
// Field positions
`define SCIBR_STS2_RPF_BIT 0
`define SCIBR_STS2_BRK_BIT 1
`define SCIBR_RATE_SEL_LSB 0
`define SCIBR_RATE_SEL_MSB 2
`define SCIBR_PRE_SEL_LSB 4
`define SCIBR_PRE_SEL_MSB 5
`define SCIBR_CTRL_RXEN_BIT 0
`define SCIBR_CTRL_NINE_BIT 1

// ==========================================================
// Reset values
`define SCIBR_RATE_RESET 3'h0
`define SCIBR_PRE_RESET 2'h0
`define SCIBR_CTRL_RESET 2'h0

// ==========================================================
// Timing counts
// Receiver samples 16 slots per bit; 64 = 4 clock cycles per slot times 16
`define SCIBR_CLK_PER_SLOT_BASE 4
`define SCIBR_SLOTS_PER_BIT 16
`define SCIBR_SLOT_LAST 4'hf
`define SCIBR_SLOT_MID 4'h7
`define SCIBR_IDLE_BITS 10
`define SCIBR_IDLE_SLOTS 8'ha0

`endif

// ==== hdl/scibr_pkg.sv ====
// Types shared by the break/status, data buffer and bit rate block
package scibr_pkg;

  typedef struct packed {
    logic [1:0] prescaleSelect;
    logic [2:0] rateDivisorSelect;
  } scibr_rate_t;

  typedef struct packed {
    logic rxFullSet;
    logic frameErrSet;
    logic ninthBit;
  } scibr_rx_event_t;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } scibr_rx_state_t;

endpackage : scibr_pkg

// ==== verification/scibr_props.sv ====
// Concurrent checks on the bus, transmit load, slot tick and receive event ports
`timescale 1ns/1ps
module scibr_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic slotTick,
  input wire logic [7:0] txData,
  input wire logic txLoad,
  input wire scibr_pkg::scibr_rx_event_t rxEvent
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Bus answer
  wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest not lowered one cycle after request");
  wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  status_upper_a: assert property (avs_read && !avs_waitrequest && avs_address == 8'h1c
    |-> avs_readdata[31:2] == 30'h0) else $error("status two upper bits not zero");
  // ==========================================================
  // Transmit path
  tx_load_seen_a: assert property (avs_write && !avs_waitrequest && avs_address == 8'h18
    && avs_byteenable[0] |=> txLoad && txData == $past(avs_writedata[7:0]))
    else $error("no transmit load after data write");
  load_cause_a: assert property (txLoad |-> $past(avs_write && !avs_waitrequest && avs_address == 8'h18))
    else $error("transmit load without data write");
  // ==========================================================
  // Receive events and slot tick
  err_with_full_a: assert property (rxEvent.frameErrSet |-> rxEvent.rxFullSet)
    else $error("framing error without receiver full");
  full_pulse_a: assert property (rxEvent.rxFullSet |=> !rxEvent.rxFullSet)
    else $error("receiver full pulse longer than one cycle");
  tick_spacing_a: assert property (slotTick |=> !slotTick [*3])
    else $error("slot ticks closer than four cycles");
  reset_quiet_a: assert property ($fell(sys_rst) |-> avs_waitrequest && !txLoad && !slotTick
    && !rxEvent.rxFullSet && avs_readdata == 32'h0) else $error("outputs not quiet after reset");
  first_tick_a: assert property ($fell(sys_rst) |-> ##[0:4] slotTick)
    else $error("slot tick not at fastest rate after reset");
endmodule : scibr_props

bind scibr_top scibr_props i_scibr_props (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .slotTick(slotTick), .txData(txData),
  .txLoad(txLoad), .rxEvent(rxEvent));

// ==== verification/scibr_remote.sv ====
// Remote serial transmitter that drives the receive line
`timescale 1ns/1ps
module scibr_remote #(
  parameter int CLK_PER_BIT = 64
) (
  input wire logic clk,
  output logic rxLine
);
  // Line starts high and holds the last stop bit level between frames
  initial rxLine = 1'b1;
  task automatic send(input logic [8:0] data, input int nBits, input logic stopBit);
    for (int i = 0; i < nBits + 2; i++) begin
      @(posedge clk);
      rxLine <= (i == 0) ? 1'b0 : (i == nBits + 1) ? stopBit : data[i - 1];
      repeat (CLK_PER_BIT - 1) @(posedge clk);
    end
  endtask : send
  task automatic idle(input int nBits);
    @(posedge clk);
    rxLine <= 1'b1;
    repeat (nBits * CLK_PER_BIT - 1) @(posedge clk);
  endtask : idle
  task automatic glitch(input int nClk);
    @(posedge clk);
    rxLine <= 1'b0;
    repeat (nClk) @(posedge clk);
    rxLine <= 1'b1;
  endtask : glitch
endmodule : scibr_remote

// ==== verification/scibr_tb_top.sv ====
// Self-checking bench for the break/status, data buffer and bit rate block
`timescale 1ns/1ps
`include "scibr_params.svh"
module scibr_tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] avsAddress = 8'h0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0;
  logic [3:0] avsByteenable = 4'h1;
  logic [31:0] avsReaddata;
  logic avsWaitrequest;
  logic rxLine;
  logic slotTick;
  logic txLoad;
  logic [7:0] txData;
  scibr_pkg::scibr_rx_event_t rxEvent;
  logic [31:0] rd;
  logic [31:0] seed = 32'ha8186f53;
  int errTotal = 0;
  int testsRun = 0;

  always #12.5 clk = ~clk;

  scibr_top i_scibr_top (.clk(clk), .sys_rst(sys_rst), .avs_address(avsAddress), .avs_read(avsRead),
    .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_byteenable(avsByteenable),
    .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest), .rxLine(rxLine), .slotTick(slotTick),
    .txData(txData), .txLoad(txLoad), .rxEvent(rxEvent));
  scibr_remote #(.CLK_PER_BIT(64)) i_scibr_remote (.clk(clk), .rxLine(rxLine));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic int tickGap(input logic [5:0] sel);
    int pd[4] = '{1, 3, 4, 13};
    return 4 * pd[sel[5:4]] * (1 << sel[2:0]);
  endfunction : tickGap
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      errTotal++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    int n;
    n = 0;
    @(posedge clk);
    avsAddress <= addr;
    avsRead <= !wr;
    avsWrite <= wr;
    avsWritedata <= wdata;
    do begin
      @(posedge clk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 50);
    rd = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    if (n >= 50) check("bus answer", 32'h0, 32'h1);
  endtask : bus
  task automatic measure(output int gap);
    int n;
    n = 0;
    gap = 0;
    do begin
      @(posedge clk);
      n++;
    end while (slotTick !== 1'b1 && n < 8000);
    do begin
      @(posedge clk);
      gap++;
    end while (slotTick !== 1'b1 && gap < 8000);
  endtask : measure
  task automatic rxFrame(input logic [8:0] d, input int nb, input logic stp, output logic [2:0] ev);
    int n;
    n = 0;
    ev = 3'h0;
    fork
      i_scibr_remote.send(d, nb, stp);
      begin
        repeat (40) @(posedge clk);
        bus(1'b0, `SCIBR_ADDR_STATUS2, 32'h0);
        check("activity in frame", 32'h1, rd & 32'h1);
        while (ev[2] !== 1'b1 && n < 2000) begin
          @(posedge clk);
          n++;
          if (rxEvent.rxFullSet === 1'b1) ev = rxEvent;
        end
        if (n >= 2000) check("frame end", 32'h0, 32'h1);
      end
    join
  endtask : rxFrame
  task automatic pulseReset;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
  endtask : pulseReset
  task automatic closeOut;
    $display("comparisons %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : closeOut

  initial begin
    // Longest run is the slowest rate measurement, well under this span
    #(25ns * 80000);
    errTotal++;
    closeOut();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [2:0] ev;
    logic [7:0] b;
    logic [5:0] sel;
    int gap;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    bus(1'b0, `SCIBR_ADDR_RATE, 32'h0);
    check("rate after reset", 32'h0, rd);
    bus(1'b0, `SCIBR_ADDR_STATUS2, 32'h0);
    check("status two after reset", 32'h0, rd);
    bus(1'b1, 8'h40, 32'hff);
    bus(1'b0, 8'h40, 32'h0);
    check("unmapped read", 32'h0, rd);
    avsByteenable <= 4'h0;
    bus(1'b1, `SCIBR_ADDR_RATE, 32'h37);
    avsByteenable <= 4'h1;
    bus(1'b0, `SCIBR_ADDR_RATE, 32'h0);
    check("rate without lane zero", 32'h0, rd);
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      sel = (i == 4) ? 6'h07 : (i == 5) ? {seed[5:4], 1'b0, seed[2:0]} : {i[1:0], 2'h0, seed[1:0]};
      bus(1'b1, `SCIBR_ADDR_RATE, {26'h0, sel});
      bus(1'b0, `SCIBR_ADDR_RATE, 32'h0);
      check("rate readback", {26'h0, sel}, rd);
      measure(gap);
      measure(gap);
      check("slot tick spacing", tickGap(sel), gap);
    end
    $display("test bit rate done");
    bus(1'b1, `SCIBR_ADDR_RATE, 32'h0);
    bus(1'b1, `SCIBR_ADDR_CTRL, 32'h1);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      b = (i == 0) ? 8'h80 : seed[7:0];
      bus(1'b1, `SCIBR_ADDR_DATA, {24'h0, ~b});
      // Store and load pulse settle one edge after the write lands
      @(posedge clk);
      check("transmit load", 32'h1, {31'h0, txLoad});
      check("transmit byte", {24'h0, ~b}, {24'h0, txData});
      rxFrame({1'b0, b}, 8, 1'b1, ev);
      check("receive event", {29'h0, 2'b10, b[7]}, {29'h0, ev});
      bus(1'b0, `SCIBR_ADDR_DATA, 32'h0);
      check("received byte", {24'h0, b}, rd);
      repeat (64 * 12) @(posedge clk);
      bus(1'b0, `SCIBR_ADDR_STATUS2, 32'h0);
      check("activity after idle", 32'h0, rd);
    end
    i_scibr_remote.glitch(12);
    repeat (200) @(posedge clk);
    bus(1'b0, `SCIBR_ADDR_STATUS2, 32'h0);
    check("activity after false start", 32'h0, rd);
    pulseReset();
    bus(1'b0, `SCIBR_ADDR_DATA, 32'h0);
    check("data kept over reset", {24'h0, b}, rd);
    $display("test reception done");
    bus(1'b1, `SCIBR_ADDR_CTRL, 32'h3);
    rxFrame(9'h0, 9, 1'b0, ev);
    check("break event", 32'h6, {29'h0, ev});
    bus(1'b0, `SCIBR_ADDR_DATA, 32'h0);
    bus(1'b0, `SCIBR_ADDR_STATUS2, 32'h0);
    check("break kept after data only", 32'h1, {31'h0, rd[1]});
    bus(1'b1, `SCIBR_ADDR_STATUS2, 32'h0);
    bus(1'b0, `SCIBR_ADDR_STATUS2, 32'h0);
    check("break after status write", 32'h1, {31'h0, rd[1]});
    bus(1'b0, `SCIBR_ADDR_DATA, 32'h0);
    bus(1'b0, `SCIBR_ADDR_STATUS2, 32'h0);
    check("break cleared", 32'h0, {31'h0, rd[1]});
    i_scibr_remote.send(9'h0, 9, 1'b0);
    bus(1'b0, `SCIBR_ADDR_STATUS2, 32'h0);
    check("no break without high", 32'h0, {31'h0, rd[1]});
    // Stuck-low line keeps frames running; high long enough to end the one under way
    i_scibr_remote.idle(12);
    rxFrame(9'h0, 9, 1'b0, ev);
    bus(1'b0, `SCIBR_ADDR_STATUS2, 32'h0);
    check("break again", 32'h1, {31'h0, rd[1]});
    pulseReset();
    bus(1'b0, `SCIBR_ADDR_STATUS2, 32'h0);
    check("break after reset", 32'h0, rd);
    $display("test break done");
    closeOut();
  end
endmodule : scibr_tb_top
